// File: hw/sram_host_defs.svh
// Timing counts and widths of the asynchronous SRAM controller.
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

`define CLK_PERIOD_NS        10
`define WRITE_TO_FLOAT_NS    18
`define DATA_SETUP_NS        25
`define WRITE_PULSE_NS       35
`define ADDR_ACCESS_NS       45
`define DATA_HOLD_NS         0
// Least times round up to whole cycles; a zero time gives zero cycles.
`define CEIL_CYC(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_PULSE_CYC_RAW     `CEIL_CYC(`WRITE_TO_FLOAT_NS + `DATA_SETUP_NS)
`define WR_MIN_CYC           `CEIL_CYC(`WRITE_PULSE_NS)
`define WR_PULSE_CYC         ((`WR_PULSE_CYC_RAW > `WR_MIN_CYC) ? `WR_PULSE_CYC_RAW : `WR_MIN_CYC)
`define RD_ACCESS_CYC        `CEIL_CYC(`ADDR_ACCESS_NS)
// Float time before the data bus is released back after a read.
`define RD_FLOAT_CYC         `CEIL_CYC(`WRITE_TO_FLOAT_NS)
`define HOLD_CYC             1
`define ADDR_W               20
`define DATA_W               16
`define CNT_W                4

`endif

// File: hw/sram_host_pkg.sv
// Types shared by the asynchronous SRAM controller.
package sram_host_pkg;
   typedef enum logic [2:0]
   {
      st_idle   = 3'b000,
      st_setup  = 3'b001,
      st_strobe = 3'b011,
      st_hold   = 3'b010,
      st_float  = 3'b110
   } host_state_t;
endpackage : sram_host_pkg

// File: hw/sync2.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ns
module sync2 #(parameter int WIDTH = 1)
(
   input  wire logic             i_clk,
   input  wire logic             i_en,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_clk)
   begin
      if (i_en)
      begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : sync2

// File: hw/sram_host.sv
// Controller that drives an asynchronous SRAM through its pins.
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module sram_host
   import sram_host_pkg::*;
(
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic                i_ce,
   input  wire logic                i_wide,
   input  wire logic                i_req,
   input  wire logic                i_we,
   input  wire logic [`ADDR_W-1:0]  i_addr,
   input  wire logic [`DATA_W-1:0]  i_wdata,
   input  wire logic [1:0]          i_lanes,
   output logic                     o_busy,
   output logic                     o_done,
   output logic [`DATA_W-1:0]       o_rdata,
   output logic                     o_rerr,
   output logic [`ADDR_W-1:0]       o_addr,
   output logic                     o_select_active_low,
   output logic                     o_select_active_high,
   output logic                     o_we_n,
   output logic                     o_oe_n,
   output logic                     o_upper_lane_enable_n,
   output logic                     o_lower_lane_enable_n,
   output logic                     o_width_sel,
   output logic [`DATA_W-1:0]       o_dq,
   output logic                     o_dq_oe,
   input  wire logic [`DATA_W-1:0]  i_dq,
   input  wire logic                i_err
);

   // ********************************************************************
   // Pin sampling
   // ********************************************************************
   logic [`DATA_W:0] pin_s;

   sync2 #(.WIDTH(`DATA_W + 1)) u_sync
   (
      .i_clk (i_clk),
      .i_en  (i_ce),
      .i_d   ({i_err, i_dq}),
      .o_q   (pin_s)
   );

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   host_state_t            state_q;
   logic [`CNT_W-1:0]      cnt_q;
   logic                   wr_q;
   logic                   wide_q;
   logic [1:0]             lanes_q;
   logic [`DATA_W-1:0]     wdata_q;

   // The count runs from the full pulse length down to zero; the strobe is low
   // while it is above zero, so it lasts exactly the pulse length in cycles.
   localparam logic [`CNT_W-1:0] WR_CNT = `CNT_W'(`WR_PULSE_CYC);
   // One extra cycle covers the input synchroniser delay.
   localparam logic [`CNT_W-1:0] RD_CNT = `CNT_W'(`RD_ACCESS_CYC + 1);
   localparam logic [`CNT_W-1:0] FL_CNT = `CNT_W'(`RD_FLOAT_CYC - 1);

   // The width strap is caught on every enabled idle cycle and held through an access.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         wide_q <= 1'b1;
      else if (i_ce && state_q == st_idle)
         wide_q <= i_wide;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_q <= st_idle;
         cnt_q   <= '0;
         wr_q    <= 1'b0;
         lanes_q <= 2'b00;
         wdata_q <= '0;
      end
      else if (i_ce)
      begin
         unique case (state_q)
            st_idle:
            begin
               // A request with no lane enabled in wide mode would do nothing.
               if (i_req && (!wide_q || i_lanes != 2'b00))
               begin
                  wr_q    <= i_we;
                  lanes_q <= wide_q ? i_lanes : 2'b01;
                  wdata_q <= i_wdata;
                  state_q <= st_setup;
               end
            end
            st_setup:
            begin
               cnt_q   <= wr_q ? WR_CNT : RD_CNT;
               state_q <= st_strobe;
            end
            st_strobe:
            begin
               if (cnt_q != '0)
                  cnt_q <= cnt_q - `CNT_W'(1);
               else
                  state_q <= st_hold;
            end
            st_hold:
            begin
               cnt_q   <= FL_CNT;
               state_q <= wr_q ? st_idle : st_float;
            end
            st_float:
            begin
               if (cnt_q != '0)
                  cnt_q <= cnt_q - `CNT_W'(1);
               else
                  state_q <= st_idle;
            end
            default:
               state_q <= st_idle;
         endcase
      end
   end

   // ********************************************************************
   // Pin drive
   // ********************************************************************
   logic act;
   assign act = (state_q == st_setup) || (state_q == st_strobe);

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_select_active_low   <= 1'b1;
         o_select_active_high  <= 1'b0;
         o_we_n                <= 1'b1;
         o_oe_n                <= 1'b1;
         o_upper_lane_enable_n <= 1'b1;
         o_lower_lane_enable_n <= 1'b1;
         o_addr                <= '0;
         o_width_sel           <= 1'b1;
      end
      else if (i_ce)
      begin
         o_width_sel <= wide_q;
         if (state_q == st_idle && i_req)
            o_addr <= i_addr;
         // Both selects are asserted together for the access.
         o_select_active_low  <= !(act || state_q == st_hold);
         o_select_active_high <= act || state_q == st_hold;
         // The write strobe is the first to rise and so ends the write, with
         // selects and lanes held two cycles longer.
         o_we_n <= !(wr_q && state_q == st_strobe && cnt_q != '0);
         // Output drive stays high in writes so the device never fights us.
         o_oe_n <= !(!wr_q && (act || state_q == st_hold));
         o_upper_lane_enable_n <= !((act || state_q == st_hold) && lanes_q[1]);
         o_lower_lane_enable_n <= !((act || state_q == st_hold) && lanes_q[0]);
      end
   end

   // Data is driven through the strobe and one cycle past its rise, so setup
   // and hold refer to the terminating write-strobe edge.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_dq    <= '0;
         o_dq_oe <= 1'b0;
      end
      else if (i_ce)
      begin
         o_dq    <= wdata_q;
         o_dq_oe <= wr_q && (state_q == st_strobe);
      end
   end

   // ********************************************************************
   // Read return
   // ********************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rdata <= '0;
         o_rerr  <= 1'b0;
         o_done  <= 1'b0;
         o_busy  <= 1'b0;
      end
      else if (i_ce)
      begin
         o_done <= (state_q == st_hold);
         o_busy <= (state_q != st_idle) || i_req;
         if (state_q == st_hold && !wr_q)
         begin
            // Disabled lanes read as zero.
            o_rdata[7:0]  <= lanes_q[0] ? pin_s[7:0]  : 8'h00;
            o_rdata[15:8] <= (lanes_q[1] && wide_q) ? pin_s[15:8] : 8'h00;
            o_rerr        <= pin_s[`DATA_W];
         end
      end
   end
endmodule : sram_host

// File: testbench/sram_host_monitor.sv
// Pin-side assertions of the SRAM controller.
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module sram_host_monitor
(
   input wire logic               i_clk,
   input wire logic               i_rst,
   input wire logic               o_busy,
   input wire logic               o_select_active_low,
   input wire logic               o_select_active_high,
   input wire logic               o_we_n,
   input wire logic               o_oe_n,
   input wire logic               o_upper_lane_enable_n,
   input wire logic               o_lower_lane_enable_n,
   input wire logic               o_width_sel,
   input wire logic [`DATA_W-1:0] o_dq,
   input wire logic               o_dq_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_WR_OVERLAP:
   assert property (!o_we_n |-> !o_select_active_low && o_select_active_high && o_oe_n
      && !(o_width_sel && o_upper_lane_enable_n && o_lower_lane_enable_n))
      else $error("strobe without select");
   AST_DATA_HELD:
   assert property (!o_we_n |-> o_dq_oe ##1 (o_dq_oe && $stable(o_dq)))
      else $error("write data moved");
   // Five cycles are the first whole count above float delay plus setup.
   AST_STROBE_LEN:
   assert property ($fell(o_we_n) |-> !o_we_n[*5]) else $error("strobe short");
   AST_NO_CLASH:
   assert property (o_dq_oe |-> o_oe_n) else $error("bus clash");
   AST_FLOAT_GAP:
   assert property ($rose(o_oe_n) |-> !o_dq_oe[*2]) else $error("no float gap");
   AST_STRAP_STILL:
   assert property (o_busy && $past(o_busy) && $past(o_busy, 2) |-> $stable(o_width_sel))
      else $error("strap moved");
endmodule : sram_host_monitor
bind sram_host sram_host_monitor mon_u (.*);

// File: testbench/sram_dev_model.sv
// Pin-level model of the asynchronous SRAM.
`timescale 1ns/1ns
module sram_dev_model
(
   input wire logic [19:0] i_addr,
   input wire logic        i_select_active_low,
   input wire logic        i_select_active_high,
   input wire logic        i_we_n,
   input wire logic        i_oe_n,
   input wire logic        i_upper_lane_enable_n,
   input wire logic        i_lower_lane_enable_n,
   input wire logic        i_wide,
   input wire logic        i_flip,
   input wire logic [15:0] i_dq,
   output logic     [15:0] o_dq,
   output logic            o_err
);
   logic [15:0] mem_q [0:15];
   logic [15:0] last_q = 16'h0000;
   logic [15:0] lane;
   logic [15:0] drv;
   logic        cs;
   logic        rd;
   assign cs = !i_select_active_low && i_select_active_high;
   assign lane = i_wide ? ~{{8{i_upper_lane_enable_n}}, {8{i_lower_lane_enable_n}}}
      : 16'h00ff;
   assign rd = cs && i_we_n && !i_oe_n;
   assign drv = rd ? lane : 16'h0000;
   // A released lane shows the inverse of the last read, so stale data never looks valid.
   assign o_dq = (drv & mem_q[i_addr[3:0]]) | (~drv & ~last_q);
   assign o_err = rd ? i_flip : !i_flip;
   always @*
   begin
      if (cs && !i_we_n && lane != 16'h0000)
         mem_q[i_addr[3:0]] = (mem_q[i_addr[3:0]] & ~lane) | (i_dq & lane);
      if (rd)
         last_q = mem_q[i_addr[3:0]];
   end
endmodule : sram_dev_model

// File: testbench/async_sram_bus_access_bench.sv
// Self-checking bench of the SRAM controller against a pin model of the memory.
`timescale 1ns/1ns
`include "sram_host_defs.svh"
module async_sram_bus_access_bench;
   logic               i_clk, i_rst, i_ce, i_wide, i_req, i_we, i_err, flip;
   logic               o_busy, o_done, o_rerr, o_we_n, o_oe_n, o_width_sel, o_dq_oe;
   logic               o_select_active_low, o_select_active_high;
   logic               o_upper_lane_enable_n, o_lower_lane_enable_n;
   logic [1:0]         i_lanes;
   logic [`ADDR_W-1:0] i_addr, o_addr;
   logic [`DATA_W-1:0] i_wdata, o_rdata, o_dq, i_dq, dev_dq;
   int                 n_errors = 0;
   int                 checks_done = 0;
   // Row: write, wide, two lane bits, address nibble, write data, expected read data.
   logic [39:0]        rows [11] = '{40'hf1_1234_0000, 40'h71_0000_1234, 40'hd1_abcd_0000,
      40'h71_0000_12cd, 40'h61_0000_1200, 40'h51_0000_00cd, 40'h82_ab77_0000,
      40'h02_0000_0077, 40'he2_5600_0000, 40'h72_0000_5677, 40'h21_0000_00cd};
   assign i_dq = o_dq_oe ? o_dq : dev_dq;
   always #5 i_clk = ~i_clk;
   sram_host dut_u (.*);
   sram_dev_model dev_u (.i_addr(o_addr), .i_select_active_low(o_select_active_low),
      .i_select_active_high(o_select_active_high), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
      .i_upper_lane_enable_n(o_upper_lane_enable_n),
      .i_lower_lane_enable_n(o_lower_lane_enable_n), .i_wide(o_width_sel),
      .i_flip(flip), .i_dq(i_dq), .o_dq(dev_dq), .o_err(i_err));
   task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s is %h, not %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // One access; after done it leaves room for the float time of a read.
   task automatic op(input logic [39:0] r);
      int n;
      {i_we, i_wide, i_lanes} = r[39:36];
      {i_addr, i_wdata} = {16'h0000, r[35:16]};
      // The strap is caught only while idle, so it settles a cycle before the request.
      @(negedge i_clk);
      i_req = 1'b1;
      @(negedge i_clk);
      i_req = 1'b0;
      for (n = 0; n < 30 && o_done !== 1'b1; n++)
         @(negedge i_clk);
      chk({19'h00000, o_done}, 20'h00001, "done");
      if (o_done !== 1'b1)
         end_sim();
      repeat (3) @(negedge i_clk);
   endtask : op
   initial
   begin
      i_clk = 1'b0;
      {i_rst, i_ce, i_wide, i_req, i_we, flip, i_lanes, i_addr, i_wdata} = {6'h38, 38'h0};
      repeat (8) @(negedge i_clk);
      i_rst = 1'b0;
      chk({o_select_active_low, o_select_active_high, o_we_n, o_oe_n, o_upper_lane_enable_n,
         o_lower_lane_enable_n, o_dq_oe, o_busy, o_done, o_width_sel}, 20'h002f1, "idle pins");
      $display("reset test done");
      for (int k = 0; k < 11; k++)
      begin
         op(rows[k]);
         if (!rows[k][39])
            chk({3'h0, o_rerr, o_rdata}, {4'h0, rows[k][15:0]}, "read");
         $display("row %0d done", k);
      end
      i_wide = 1'b1;
      @(negedge i_clk);
      {i_ce, i_we, i_lanes, i_req} = 5'b01111;
      repeat (3) @(negedge i_clk);
      chk({18'h0, o_select_active_low, o_we_n}, 20'h00003, "held off");
      {i_ce, i_lanes} = 3'b100;
      repeat (3) @(negedge i_clk);
      chk({18'h0, o_select_active_low, o_we_n}, 20'h00003, "no lane");
      i_req = 1'b0;
      $display("refusal test done");
      flip = 1'b1;
      op(40'h71_0000_0000);
      chk({19'h0, o_rerr}, 20'h00001, "error flag");
      flip = 1'b0;
      $display("error flag test done");
      {i_addr, i_wdata, i_we, i_lanes, i_req} = {20'h00003, 16'h5555, 4'hf};
      repeat (4) @(negedge i_clk);
      {i_req, i_rst} = 2'b01;
      @(negedge i_clk);
      i_rst = 1'b0;
      chk({18'h0, o_we_n, o_dq_oe}, 20'h00002, "abort");
      op(40'hf3_9a5c_0000);
      op(40'h73_0000_0000);
      chk({4'h0, o_rdata}, 20'h09a5c, "after abort");
      $display("abort test done");
      end_sim();
   end
endmodule : async_sram_bus_access_bench
